// ==== inc/timer_two_defines.vh ====
// Purpose: constants for the timer two block
// Assumes: word-aligned APB registers, byte data in the low bits
// Notes:   definitions only
`ifndef TIMER_TWO_DEFINES_VH
`define TIMER_TWO_DEFINES_VH
// register printed indices (byte offsets are 4 * index, so c9 sits at byte offset 0x324)
`define IDX_CONTROL      8'hc8
`define IDX_MODE         8'hc9
`define IDX_COUNT_LOW    8'hca
`define IDX_COUNT_HIGH   8'hcb
`define IDX_CAPTURE_LOW  8'hcc
`define IDX_CAPTURE_HIGH 8'hcd
`define IDX_IRQ_ENABLE   8'hce
// control bit positions
`define CTL_OVF    7
`define CTL_EXF    6
`define CTL_RCLK   5
`define CTL_UART_TX_CLOCK_SELECT   4
`define CTL_EXEN   3
`define CTL_RUN    2
`define CTL_CT     1
`define CTL_CPRL   0
// mode bit positions
`define MOD_OE     1
`define MOD_DOWN_COUNT_ENABLE   0
`define MOD_MASK   8'h03
`define CTL_RESET  8'h00
`define MOD_RESET  8'h00
`define COUNT_TOP  16'hffff
`define COUNT_ZERO 16'h0000
// machine cycle divide
`define MC_DIV     3'd6
`endif

// ==== logic/fall_detect.v ====
// Purpose: falling edge detect on a pin sampled once per machine cycle
// Assumes: pin synchronous to clk
// Notes:   pulse one cycle after the low sample
`timescale 1ns/1ps
`default_nettype none
module fall_detect
(
    input  wire clk,
    input  wire rst_b,
    input  wire sample,
    input  wire pin,
    output reg  fall
);
    reg last_ff;
    // 1 then 0 on successive samples
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            last_ff <= 1'b1;
            fall    <= 1'b0;
        end
        else
        begin
            fall <= sample & last_ff & ~pin;
            if (sample)
                last_ff <= pin;
        end
    end
endmodule // fall_detect
`default_nettype wire

// ==== logic/cycle_tick.v ====
// Purpose: machine-cycle tick generator
// Assumes: one system clock
// Notes:   one pulse every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module cycle_tick
#(
    parameter [2:0] DIV = 3'd6
)
(
    input  wire clk,
    input  wire rst_b,
    output reg  tick
);
    reg [2:0] cnt_ff;
    // free divider
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            cnt_ff <= 3'd0;
            tick   <= 1'b0;
        end
        else
        begin
            tick   <= (cnt_ff == DIV - 3'd1);
            cnt_ff <= (cnt_ff == DIV - 3'd1) ? 3'd0 : cnt_ff + 3'd1;
        end
    end
endmodule // cycle_tick
`default_nettype wire

// ==== logic/timer_two.v ====
// Purpose: 16-bit timer/counter with capture/reload, APB registers
// Assumes: pins synchronous to clk; APB slave, zero wait states
// Notes:   byte address = 4 * printed index
// Overview of operation
// - mode from run, select, output enable, uart
// - counts only while run bit set
// - overflow flag sticky, not in baud/clockout
// - external flag on trigger fall if enabled and running, not in clock-out or down count
// - receive clock uses timer overflows
// - transmit clock uses timer overflows
// - trigger enable gates capture or reload
// - source: machine cycles, count pin falls, or every clock in baud/clock-out
// - capture or reload on trigger per select
// - uart select forces auto-reload on overflow
// - control resets zero; mode byte register
// - output enable only in clock-out mode
// - down-count enable allows up/down counting
// - capture mode without trigger: plain counter
// - trigger fall copies count into capture
// - capture mode never reloads count
// - one interrupt from either flag
// - up rollover sets flag, loads capture, or zero in capture mode
// - edge: 1 then 0, flag third cycle
// - down count to capture, reload top, toggle
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "timer_two_defines.vh"
`default_nettype none
module timer_two
(
    input  wire        clk,
    input  wire        rst_b,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        count_pin,
    input  wire        trigger_pin,
    input  wire        uart_mode_13,
    output reg         timer_irq,
    output reg         uart_rx_tick,
    output reg         uart_tx_tick,
    output reg         clock_out,
    output reg         clock_out_oe
);
    localparam [3:0] M_OFF    = 4'b0001;
    localparam [3:0] M_RELOAD = 4'b0010;
    localparam [3:0] M_CAPT   = 4'b0100;
    localparam [3:0] M_BAUD   = 4'b1000;

    reg  [7:0]  control_ff;
    reg  [7:0]  mode_ff;
    reg  [15:0] count_ff;
    reg  [15:0] capture_ff;
    reg         irq_en_ff;
    reg         nxt_ovf;
    reg         nxt_exf;
    reg  [15:0] nxt_count;
    reg  [15:0] nxt_capture;
    reg  [3:0]  mode_sel;
    reg         clkout_mode;
    reg         inc;
    reg         ovf_evt;
    reg         exf_evt;
    reg         rd_err;
    reg  [7:0]  rd_byte;
    wire        mc_tick;
    wire        trig_fall;
    wire        cnt_fall;
    wire        wr_acc;
    wire [9:0]  widx;
    wire        uart_sel;
    wire        down;

    // byte address to printed index
    function [7:0] idx_of;
        input [11:0] a;
        begin
            idx_of = a[9:2];
        end
    endfunction

    // APB access phase, zero wait
    assign wr_acc = psel & penable & pwrite;
    assign widx   = {2'b00, idx_of(paddr)};
    assign uart_sel = control_ff[`CTL_RCLK] | control_ff[`CTL_UART_TX_CLOCK_SELECT];
    assign down   = mode_ff[`MOD_DOWN_COUNT_ENABLE] & ~trigger_pin;

    // machine-cycle tick
    cycle_tick #(.DIV(`MC_DIV)) u_tick
    (
        .clk   (clk),
        .rst_b (rst_b),
        .tick  (mc_tick)
    );

    // trigger edge, sampled per machine cycle
    fall_detect u_trig
    (
        .clk    (clk),
        .rst_b  (rst_b),
        .sample (mc_tick),
        .pin    (trigger_pin),
        .fall   (trig_fall)
    );

    // count pin edge, sampled per machine cycle
    fall_detect u_cnt
    (
        .clk    (clk),
        .rst_b  (rst_b),
        .sample (mc_tick),
        .pin    (count_pin),
        .fall   (cnt_fall)
    );

    // mode decode
    always @*
    begin
        clkout_mode = 1'b0;
        if (!control_ff[`CTL_RUN])
            mode_sel = M_OFF;
        else if (uart_sel)
            mode_sel = M_BAUD;
        else if (mode_ff[`MOD_OE])
        begin
            mode_sel    = M_RELOAD;
            clkout_mode = ~control_ff[`CTL_CPRL] & ~control_ff[`CTL_CT];
        end
        else if (control_ff[`CTL_CPRL])
            mode_sel = M_CAPT;
        else
            mode_sel = M_RELOAD;
    end

    // count source and counter step
    always @*
    begin
        inc = 1'b0;
        if (mode_sel != M_OFF)
        begin
            if (control_ff[`CTL_CT])
                inc = cnt_fall;
            else if (mode_sel == M_BAUD || clkout_mode)
                inc = 1'b1;
            else
                inc = mc_tick;
        end
    end

    // next count, capture and flags
    always @*
    begin
        nxt_count   = count_ff;
        nxt_capture = capture_ff;
        nxt_ovf     = control_ff[`CTL_OVF];
        nxt_exf     = control_ff[`CTL_EXF];
        ovf_evt     = 1'b0;
        exf_evt     = 1'b0;
        // software writes first so hardware sets win
        if (wr_acc && widx == {2'b00, `IDX_CONTROL})
        begin
            nxt_ovf = pwdata[`CTL_OVF];
            nxt_exf = pwdata[`CTL_EXF];
        end
        if (wr_acc && widx == {2'b00, `IDX_COUNT_LOW})
            nxt_count[7:0] = pwdata[7:0];
        if (wr_acc && widx == {2'b00, `IDX_COUNT_HIGH})
            nxt_count[15:8] = pwdata[7:0];
        if (wr_acc && widx == {2'b00, `IDX_CAPTURE_LOW})
            nxt_capture[7:0] = pwdata[7:0];
        if (wr_acc && widx == {2'b00, `IDX_CAPTURE_HIGH})
            nxt_capture[15:8] = pwdata[7:0];
        if (inc)
        begin
            if (down && mode_sel == M_RELOAD && !clkout_mode)
            begin
                if (count_ff == capture_ff)
                begin
                    ovf_evt   = 1'b1;
                    nxt_count = `COUNT_TOP;
                end
                else
                    nxt_count = count_ff - 16'h0001;
            end
            else if (count_ff == `COUNT_TOP)
            begin
                ovf_evt = 1'b1;
                if (mode_sel == M_CAPT)
                    nxt_count = `COUNT_ZERO;
                else
                    nxt_count = capture_ff;
            end
            else
                nxt_count = count_ff + 16'h0001;
        end
        if (ovf_evt && mode_sel != M_BAUD && !clkout_mode)
            nxt_ovf = 1'b1;
        if (ovf_evt && mode_ff[`MOD_DOWN_COUNT_ENABLE] && mode_sel == M_RELOAD && !clkout_mode)
            nxt_exf = ~control_ff[`CTL_EXF];
        // trigger events
        if (trig_fall && control_ff[`CTL_EXEN] && mode_sel != M_OFF && !clkout_mode
            && !(mode_ff[`MOD_DOWN_COUNT_ENABLE] && mode_sel == M_RELOAD))
        begin
            exf_evt = 1'b1;
            nxt_exf = 1'b1;
            if (mode_sel == M_CAPT)
                nxt_capture = count_ff;
            else if (mode_sel == M_RELOAD)
                nxt_count = capture_ff;
        end
    end

    // register state
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            control_ff <= `CTL_RESET;
            mode_ff    <= `MOD_RESET;
            count_ff   <= `COUNT_ZERO;
            capture_ff <= `COUNT_ZERO;
            irq_en_ff  <= 1'b0;
        end
        else
        begin
            count_ff   <= nxt_count;
            capture_ff <= nxt_capture;
            control_ff[`CTL_OVF] <= nxt_ovf;
            control_ff[`CTL_EXF] <= nxt_exf;
            if (wr_acc && widx == {2'b00, `IDX_CONTROL})
                control_ff[5:0] <= pwdata[5:0];
            if (wr_acc && widx == {2'b00, `IDX_MODE})
                mode_ff <= pwdata[7:0] & `MOD_MASK;
            if (wr_acc && widx == {2'b00, `IDX_IRQ_ENABLE})
                irq_en_ff <= pwdata[0];
        end
    end

    // read mux
    always @*
    begin
        rd_err  = 1'b0;
        rd_byte = 8'h00;
        case (widx)
            {2'b00, `IDX_CONTROL}:      rd_byte = control_ff;
            {2'b00, `IDX_MODE}:         rd_byte = mode_ff;
            {2'b00, `IDX_COUNT_LOW}:    rd_byte = count_ff[7:0];
            {2'b00, `IDX_COUNT_HIGH}:   rd_byte = count_ff[15:8];
            {2'b00, `IDX_CAPTURE_LOW}:  rd_byte = capture_ff[7:0];
            {2'b00, `IDX_CAPTURE_HIGH}: rd_byte = capture_ff[15:8];
            {2'b00, `IDX_IRQ_ENABLE}:   rd_byte = {7'h00, irq_en_ff};
            default:                    rd_err  = 1'b1;
        endcase
    end

    // registered outputs
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            prdata       <= 32'h00000000;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            timer_irq    <= 1'b0;
            uart_rx_tick <= 1'b0;
            uart_tx_tick <= 1'b0;
            clock_out    <= 1'b0;
            clock_out_oe <= 1'b0;
        end
        else
        begin
            // answer in the cycle after setup
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & rd_err;
            prdata  <= {24'h000000, rd_byte};
            timer_irq <= irq_en_ff & (nxt_ovf | nxt_exf);
            uart_rx_tick <= control_ff[`CTL_RCLK] & uart_mode_13 & ovf_evt;
            uart_tx_tick <= control_ff[`CTL_UART_TX_CLOCK_SELECT] & uart_mode_13 & ovf_evt;
            clock_out_oe <= clkout_mode;
            if (clkout_mode && ovf_evt)
                clock_out <= ~clock_out;
        end
    end
endmodule // timer_two
`default_nettype wire

// ==== bench/timer_two_assertions.sv ====
// Purpose: port checks for timer two
// Assumes: software bits shadowed from apb writes
// Notes:   bound to timer_two
`timescale 1ns/1ps
`default_nettype none
module timer_two_assertions
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        timer_irq,
    input wire logic        uart_rx_tick,
    input wire logic        uart_tx_tick,
    input wire logic        clock_out,
    input wire logic        clock_out_oe
);
    logic [7:0] ctl_sh;
    logic [1:0] mod_sh;
    logic       ien_sh;
    wire  logic wr_en;
    wire  logic co_mode;
    // shadow of software written bits
    assign wr_en = psel && penable && pready && pwrite;
    assign co_mode = ctl_sh[2] && mod_sh[1] && !ctl_sh[5] && !ctl_sh[4] && !ctl_sh[0] && !ctl_sh[1];
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            ctl_sh <= 8'h00;
        else if (wr_en && paddr[9:2] == 8'hc8)
            ctl_sh <= pwdata[7:0];
    end
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            mod_sh <= 2'h0;
        else if (wr_en && paddr[9:2] == 8'hc9)
            mod_sh <= pwdata[1:0];
    end
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            ien_sh <= 1'b0;
        else if (wr_en && paddr[9:2] == 8'hce)
            ien_sh <= pwdata[0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    AST_APB_ANSWER: assert property (s_setup |=> s_access)
        else $error("no answer after setup");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_MODE_READ: assert property (pready && !pwrite && paddr[9:2] == 8'hc9 |-> prdata == {30'h0, mod_sh})
        else $error("mode readback wrong");
    AST_OE_MODE: assert property (co_mode == $past(co_mode) |-> clock_out_oe == co_mode)
        else $error("output enable wrong");
    AST_CLKOUT_HOLD: assert property ($changed(clock_out) |-> clock_out_oe || $past(clock_out_oe))
        else $error("clock out moved outside mode");
    AST_TX_SEL: assert property (uart_tx_tick |-> ctl_sh[4] || $past(ctl_sh[4]))
        else $error("tx tick without select");
    AST_RX_SEL: assert property (uart_rx_tick |-> ctl_sh[5] || $past(ctl_sh[5]))
        else $error("rx tick without select");
    AST_IRQ_MASK: assert property (!ien_sh && !$past(ien_sh) |-> !timer_irq)
        else $error("irq while disabled");
    AST_STOP_QUIET: assert property (!ctl_sh[2] && !$past(ctl_sh[2]) |-> !uart_rx_tick && !uart_tx_tick)
        else $error("tick while stopped");
endmodule // timer_two_assertions
bind timer_two timer_two_assertions u_chk (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer_irq, .uart_rx_tick, .uart_tx_tick, .clock_out, .clock_out_oe);
`default_nettype wire

// ==== bench/ext_pins.sv ====
// Purpose: count pin, trigger pin and uart side
// Assumes: pins idle high
// Notes:   levels held two machine cycles
`timescale 1ns/1ps
`default_nettype none
module ext_pins
(
    input  wire logic clk,
    output var  logic count_pin,
    output var  logic trigger_pin,
    output var  logic uart_mode_13
);
    // idle levels, uart in mode 1 or 3
    initial
    begin
        count_pin = 1'b1;
        trigger_pin = 1'b1;
        uart_mode_13 = 1'b1;
    end
    // n falls, well under the rate limit
    task automatic pulse_count(input int n);
        repeat (n)
        begin
            repeat (12) @(posedge clk);
            count_pin <= 1'b0;
            repeat (12) @(posedge clk);
            count_pin <= 1'b1;
        end
    endtask
    // hold the trigger pin at a level, used as count direction
    task automatic set_trig(input logic v);
        @(posedge clk);
        trigger_pin <= v;
    endtask
    // high sample, then low sample
    task automatic trig_fall;
        repeat (12) @(posedge clk);
        trigger_pin <= 1'b0;
        repeat (12) @(posedge clk);
        trigger_pin <= 1'b1;
    endtask
endmodule // ext_pins
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: self-checking bench for timer two
// Assumes: zero wait apb slave
// Notes:   one task per scenario
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; $display("Error %0t: got %h want %h", $time, a, e); end end
module tb;
    logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, cnt_on = 0, perr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, q;
    logic [7:0]  cl;
    logic        co;
    wire  logic [31:0] prdata;
    wire  logic  pready, pslverr, count_pin, trigger_pin, uart_mode_13, timer_irq;
    wire  logic  uart_rx_tick, uart_tx_tick, clock_out, clock_out_oe;
    int          err_count = 0, checks = 0, rx_n = 0, tx_n = 0;
    ext_pins pins (.clk(clk), .count_pin(count_pin), .trigger_pin(trigger_pin), .uart_mode_13(uart_mode_13));
    timer_two dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_pin(count_pin),
        .trigger_pin(trigger_pin), .uart_mode_13(uart_mode_13), .timer_irq(timer_irq),
        .uart_rx_tick(uart_rx_tick), .uart_tx_tick(uart_tx_tick), .clock_out(clock_out),
        .clock_out_oe(clock_out_oe));
    // clock and rx/tx tick counters
    always #5 clk = ~clk;
    always @(posedge clk)
        if (cnt_on)
        begin
            rx_n <= rx_n + uart_rx_tick;
            tx_n <= tx_n + uart_tx_tick;
        end
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) err_count++;
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d); apb(1'b1, i, d); endtask
    task automatic rd(input logic [7:0] i); apb(1'b0, i, 8'h00); endtask
    // reset values and unmapped place
    task automatic t_reset;
        rd(8'hc8); `CHK(q, 32'h0)
        rd(8'hc9); `CHK(q, 32'h0)
        rd(8'h10); `CHK({perr, q}, 33'h100000000)
    endtask
    // capture on trigger, counting goes on, shared irq
    task automatic t_capture;
        wr(8'hcb, 8'h12); wr(8'hc8, 8'h0d); pins.trig_fall(); repeat (12) @(posedge clk);
        rd(8'hcd); `CHK(q[7:0], 8'h12)
        rd(8'hcc); cl = q[7:0]; rd(8'hc8); `CHK(q[7:6], 2'b01)
        rd(8'hca); `CHK(q[7:0] > cl, 1'b1)
        wr(8'hce, 8'h01); repeat (2) @(posedge clk); `CHK(timer_irq, 1'b1)
        wr(8'hc8, 8'h00); repeat (2) @(posedge clk); `CHK(timer_irq, 1'b0)
        wr(8'hce, 8'h00);
    endtask
    // rollover reloads from capture, stop holds count
    task automatic t_reload;
        wr(8'hcc, 8'hcd); wr(8'hcd, 8'hab); wr(8'hca, 8'hfe); wr(8'hcb, 8'hff); wr(8'hc8, 8'h04);
        repeat (30) @(posedge clk);
        rd(8'hc8); `CHK(q[7:0], 8'h84)
        wr(8'hc8, 8'h80); rd(8'hcb); `CHK(q[7:0], 8'hab)
        rd(8'hca); cl = q[7:0]; repeat (30) @(posedge clk);
        rd(8'hca); `CHK(q[7:0], cl)
        rd(8'hc8); `CHK(q[7:0], 8'h80)
    endtask
    // counting falls of the count pin
    task automatic t_count;
        wr(8'hc8, 8'h00); wr(8'hca, 8'h00); wr(8'hcb, 8'h00); wr(8'hc8, 8'h06);
        pins.pulse_count(5); repeat (12) @(posedge clk); wr(8'hc8, 8'h02);
        rd(8'hca); `CHK(q[7:0], 8'h05)
    endtask
    // trigger fall forces reload when enabled
    task automatic t_trig_reload;
        wr(8'hca, 8'h00); wr(8'hcb, 8'h00); wr(8'hc8, 8'h0e); pins.trig_fall(); repeat (12) @(posedge clk);
        rd(8'hcb); `CHK(q[7:0], 8'hab)
        rd(8'hc8); `CHK(q[7:0], 8'h4e)
    endtask
    // down count: underflow at capture sets overflow flag, toggles external flag
    task automatic t_down;
        wr(8'hc8, 8'h00); wr(8'hc9, 8'h01); wr(8'hcc, 8'hfc); wr(8'hcd, 8'hff);
        wr(8'hca, 8'hff); wr(8'hcb, 8'hff); pins.set_trig(1'b0);
        wr(8'hc8, 8'h04); repeat (36) @(posedge clk); wr(8'hc8, 8'hc0);
        rd(8'hc8); `CHK(q[7:0], 8'hc0)
        rd(8'hcb); `CHK(q[7:0], 8'hff)
        wr(8'hc9, 8'h00); pins.set_trig(1'b1);
    endtask
    // baud mode: ticks every 16 clocks, no overflow flag
    task automatic t_baud;
        wr(8'hc8, 8'h00); wr(8'hcc, 8'hf0); wr(8'hcd, 8'hff); wr(8'hca, 8'hf0); wr(8'hcb, 8'hff);
        wr(8'hc8, 8'h34); rx_n <= 0; tx_n <= 0; cnt_on <= 1'b1; repeat (160) @(posedge clk); cnt_on <= 1'b0;
        `CHK(rx_n >= 9 && rx_n <= 11, 1'b1)
        `CHK(tx_n >= 9 && tx_n <= 11, 1'b1)
        rd(8'hc8); `CHK(q[7], 1'b0)
    endtask
    // clock-out mode and reserved mode bits
    task automatic t_clkout;
        wr(8'hc9, 8'h02); wr(8'hc8, 8'h04); repeat (3) @(posedge clk); `CHK(clock_out_oe, 1'b1)
        co = clock_out; repeat (16) @(posedge clk); `CHK(clock_out, ~co)
        repeat (100) @(posedge clk); rd(8'hc8); `CHK(q[7:0], 8'h04)
        wr(8'hc8, 8'h00); wr(8'hc9, 8'hff); rd(8'hc9); `CHK(q[7:0], 8'h03)
        wr(8'hc9, 8'h00);
    endtask
    task automatic results;
        $display("Errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #200000;
        err_count++;
        results();
    end
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_capture();
        t_reload();
        t_count();
        t_trig_reload();
        t_down();
        t_baud();
        t_clkout();
        results();
    end
endmodule // tb
`default_nettype wire
